// *** core/uhbp_port.sv ***
// What this block does
// - The three register-select bits choose which internal register a host access reaches.
// - The device is selected only with both high selects at 1 and the low select at 0.
// - A read happens when either the low-active or the high-active read strobe is asserted.
// - With the address latch held low from the start, the live selects and index are used.
// - The eight-bit data bus is driven toward the host on reads and sampled on writes.
// - Data bit zero is the least significant bit and maps straight to register bit zero.
// - While read and selected, the addressed register contents go onto the data bus.
// - While write and selected with no read strobe asserted, the host data is loaded into the addressed register.
// - The drive-disable output is 0 while the host reads from the device.
// - The select indicator is high while the chip selects show the device enabled.
`timescale 1ns/10ps
`default_nettype none
module uhbp_port
    import uhbp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Host address and selects
    input  wire logic [IDX_W-1:0]  reg_index,
    input  wire logic              select_a_hi,
    input  wire logic              select_b_hi,
    input  wire logic              select_c_n,
    input  wire logic              addr_latch_n,
    // Host strobes
    input  wire logic              read_strobe_n,
    input  wire logic              read_strobe_hi,
    input  wire logic              write_strobe_n,
    input  wire logic              write_strobe_hi,
    // Host data bus, split three ways
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    // Host side indicators
    output logic                   drive_disable_n,
    output logic                   selected_indicator,
    // Access events toward the rest of the device
    output uhbp_wr_type            wr_evt,
    output uhbp_rd_type            rd_evt
);

    // ----------------------------------------------------------
    // Address latch
    // ----------------------------------------------------------
    uhbp_addr_type  live_addr;
    uhbp_addr_type  lat_addr_r;
    uhbp_addr_type  eff_addr;
    logic           latch_prev_r;
    logic           tied_low_r;
    logic           latch_fall;
    logic           sel_eff;
    logic           rd_act;
    logic           wr_act;
    logic [DATA_W-1:0] rd_data;
    uhbp_state_type state_r;
    uhbp_state_type state_nxt;
    logic           wr_start;

    assign live_addr = '{sel_a: select_a_hi, sel_b: select_b_hi,
                         sel_c_n: select_c_n, idx: reg_index};
    assign latch_fall = latch_prev_r && !addr_latch_n;

    // Previous level of the latch strobe; resets to the tied-low level so a
    // strobe held low gives no false edge after reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            latch_prev_r <= 1'b0;
        end else if (ce) begin
            latch_prev_r <= addr_latch_n;
        end
    end

    // Strobe never seen high since reset means it is tied low
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tied_low_r <= 1'b1;
        end else if (ce && addr_latch_n) begin
            tied_low_r <= 1'b0;
        end
    end

    // Capture on the falling edge only
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lat_addr_r <= '{sel_a: ~SEL_HI_ON, sel_b: ~SEL_HI_ON,
                            sel_c_n: ~SEL_LO_ON, idx: IDX_RESET};
        end else if (ce && latch_fall) begin
            lat_addr_r <= live_addr;
        end
    end

    // Edge cycle passes live values so a same-cycle strobe sees them
    always_comb begin
        if (tied_low_r || latch_fall) begin
            eff_addr = live_addr;
        end else begin
            eff_addr = lat_addr_r;
        end
    end

    // ----------------------------------------------------------
    // Select and strobe decode
    // ----------------------------------------------------------
    assign sel_eff = uhbp_is_selected(eff_addr);
    // Strobes are ignored unless selected
    assign rd_act  = sel_eff && ((read_strobe_n == STROBE_N_ON) ||
                                 (read_strobe_hi == STROBE_H_ON));
    assign wr_act  = sel_eff && ((write_strobe_n == STROBE_N_ON) ||
                                 (write_strobe_hi == STROBE_H_ON));

    // ----------------------------------------------------------
    // Access state machine
    // ----------------------------------------------------------
    // Read wins when both strobes overlap; a write is taken once per strobe
    always_comb begin
        state_nxt = state_r;
        wr_start  = 1'b0;
        unique case (state_r)
            ST_IDLE: begin
                if (rd_act) begin
                    state_nxt = ST_READ;
                end else if (wr_act) begin
                    state_nxt = ST_WRITE;
                    wr_start  = 1'b1;
                end
            end
            ST_READ: begin
                if (!rd_act) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (!wr_act) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // ----------------------------------------------------------
    // Register store
    // ----------------------------------------------------------
    uhbp_regs u_regs (
        .clock   (clock),
        .rstn    (rstn),
        .ce      (ce),
        .wr_en   (wr_start),
        .wr_idx  (eff_addr.idx),
        .wr_data (data_in),
        .rd_idx  (eff_addr.idx),
        .rd_data (rd_data)
    );

    // ----------------------------------------------------------
    // Host bus outputs
    // ----------------------------------------------------------
    // Data refreshed every read cycle, so a changed register shows at once
    always_ff @(posedge clock) begin
        if (!rstn) begin
            data_out <= REG_RESET;
        end else if (ce && rd_act) begin
            data_out <= rd_data;
        end
    end

    // Bus floats whenever no selected read is active
    always_ff @(posedge clock) begin
        if (!rstn) begin
            data_oe         <= 1'b0;
            drive_disable_n <= 1'b1;
        end else if (ce) begin
            data_oe         <= rd_act;
            drive_disable_n <= !rd_act;
        end
    end

    // Follows the same select view the accesses use
    always_ff @(posedge clock) begin
        if (!rstn) begin
            selected_indicator <= 1'b0;
        end else if (ce) begin
            selected_indicator <= sel_eff;
        end
    end

    // ----------------------------------------------------------
    // Access events
    // ----------------------------------------------------------
    // One-cycle pulses at the start of each access
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_evt <= '{valid: 1'b0, idx: IDX_RESET, data: REG_RESET};
            rd_evt <= '{valid: 1'b0, idx: IDX_RESET};
        end else if (ce) begin
            wr_evt <= '{valid: wr_start, idx: eff_addr.idx, data: data_in};
            rd_evt <= '{valid: (state_r == ST_IDLE) && rd_act, idx: eff_addr.idx};
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_select_indicator: assert property (ce && sel_eff |=> selected_indicator)
        else $error("select indicator low while selected");
    a_select_decode: assert property (ce && tied_low_r |->
                                      sel_eff == (select_a_hi && select_b_hi && !select_c_n))
        else $error("select decode wrong");
    a_read_drives: assert property (ce && rd_act |=> data_oe && !drive_disable_n)
        else $error("bus not driven during read");
    a_idle_float: assert property (ce && !rd_act |=> !data_oe && drive_disable_n)
        else $error("bus driven outside a read");
    a_read_data: assert property (ce && rd_act |=> data_out == $past(rd_data))
        else $error("read data not the addressed register");
    a_write_once: assert property (wr_evt.valid && ce |=> !wr_evt.valid)
        else $error("write event longer than one cycle");
    a_write_cause: assert property (ce && wr_start |=>
                                    wr_evt.valid && wr_evt.idx == $past(eff_addr.idx))
        else $error("write not taken at addressed register");
    a_unsel_nowrite: assert property (ce && !sel_eff |-> !wr_start)
        else $error("write taken while unselected");
    a_latch_capture: assert property (ce && latch_fall |=> lat_addr_r == $past(live_addr))
        else $error("address latch missed falling edge");
    a_tied_live: assert property (tied_low_r |-> eff_addr == live_addr)
        else $error("tied latch did not pass live address");

    c_read: cover property (ce && rd_act ##1 data_oe);
    c_write: cover property (ce && wr_start);
    c_latched_access: cover property (!tied_low_r && latch_fall ##[1:8] (rd_act || wr_start));
    c_hi_strobe_read: cover property (ce && rd_act && read_strobe_n);

endmodule : uhbp_port
`default_nettype wire

// *** common/uhbp_pkg.sv ***
package uhbp_pkg;

    // --------------------------------------------------------------
    // Widths and sizes
    // --------------------------------------------------------------
    localparam int          IDX_W     = 3;
    localparam int          DATA_W    = 8;
    localparam int          REG_COUNT = 8;

    // --------------------------------------------------------------
    // Levels and reset values
    // --------------------------------------------------------------
    localparam logic              SEL_HI_ON   = 1'b1;   // Active-high select level
    localparam logic              SEL_LO_ON   = 1'b0;   // Active-low select level
    localparam logic              STROBE_N_ON = 1'b0;   // Active-low strobe level
    localparam logic              STROBE_H_ON = 1'b1;   // Active-high strobe level
    localparam logic [DATA_W-1:0] REG_RESET   = 8'h00;
    localparam logic [IDX_W-1:0]  IDX_RESET   = 3'h0;

    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef struct packed {
        logic             sel_a;
        logic             sel_b;
        logic             sel_c_n;
        logic [IDX_W-1:0] idx;
    } uhbp_addr_type;

    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] data;
    } uhbp_wr_type;

    typedef struct packed {
        logic             valid;
        logic [IDX_W-1:0] idx;
    } uhbp_rd_type;

    // Access state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } uhbp_state_type;

    // Device counts as selected only with both high selects at 1 and low select at 0
    function automatic logic uhbp_is_selected(input uhbp_addr_type a);
        return (a.sel_a == SEL_HI_ON) && (a.sel_b == SEL_HI_ON) && (a.sel_c_n == SEL_LO_ON);
    endfunction : uhbp_is_selected

endpackage : uhbp_pkg

// *** core/uhbp_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module uhbp_regs
    import uhbp_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Write side
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    // Read side
    input  wire logic [IDX_W-1:0]  rd_idx,
    output logic      [DATA_W-1:0] rd_data
);

    logic [DATA_W-1:0] mem_r [REG_COUNT];

    // ----------------------------------------------------------
    // Register store
    // ----------------------------------------------------------
    // Byte stored bit for bit, bit 0 stays least significant
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_r[i] <= REG_RESET;
            end
        end else if (ce && wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    // Combinational read, registered by the caller
    assign rd_data = mem_r[rd_idx];

endmodule : uhbp_regs
`default_nettype wire

// *** testbench/uhbp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module uhbp_host_model
    import uhbp_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Host drive toward the port
    output logic      [IDX_W-1:0]  reg_index,
    output logic                   select_a_hi,
    output logic                   select_b_hi,
    output logic                   select_c_n,
    output logic                   addr_latch_n,
    output logic                   read_strobe_n,
    output logic                   read_strobe_hi,
    output logic                   write_strobe_n,
    output logic                   write_strobe_hi,
    output logic      [DATA_W-1:0] data_in,
    // Answers from the port
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe,
    input  wire logic              drive_disable_n,
    input  wire logic              selected_indicator,
    input  wire uhbp_wr_type       wr_evt,
    input  wire uhbp_rd_type       rd_evt
);
    // ------------------------------------------------------------
    // Bus levels
    // ------------------------------------------------------------
    logic              host_drv;
    logic [DATA_W-1:0] host_d;
    logic [DATA_W-1:0] last_r;

    // Idle host, deselected, latch tied low from power-up
    initial begin
        {select_a_hi, select_b_hi, select_c_n} = 3'b001;
        reg_index = 3'h0;
        addr_latch_n = 1'b0;
        {read_strobe_n, read_strobe_hi, write_strobe_n, write_strobe_hi} = 4'b1010;
        host_drv = 1'b0;
        host_d = 8'h00;
        last_r = 8'h00;
    end

    // No keeper on the bus: a floating bus shows the inverse of its last level
    assign data_in = data_oe ? data_out : (host_drv ? host_d : ~last_r);
    always @(posedge clock) last_r <= data_in;

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Address, selects and strobes change together just after an edge
    task automatic drive(input logic [2:0] sel, input logic [IDX_W-1:0] idx,
                         input logic [3:0] strb);
        @(posedge clock);
        {select_a_hi, select_b_hi, select_c_n} <= sel;
        reg_index <= idx;
        {read_strobe_n, read_strobe_hi, write_strobe_n, write_strobe_hi} <= strb;
    endtask : drive

    // Strobe held to the taking edge, then one idle cycle before the next write
    task automatic bus_write(input logic [2:0] sel, input logic [IDX_W-1:0] idx,
                             input logic [DATA_W-1:0] d, input logic hi,
                             output uhbp_wr_type ev, output logic ind);
        drive(sel, idx, hi ? 4'b1011 : 4'b1000);
        host_drv <= 1'b1;
        host_d <= d;
        @(posedge clock);
        {read_strobe_n, read_strobe_hi, write_strobe_n, write_strobe_hi} <= 4'b1010;
        host_drv <= 1'b0;
        #1;
        ev = wr_evt;
        ind = selected_indicator;
        @(posedge clock);
    endtask : bus_write

    // Flags: enable and drive-disable during the read, then one cycle after
    task automatic bus_read(input logic [2:0] sel, input logic [IDX_W-1:0] idx,
                            input logic hi, output logic [DATA_W-1:0] d,
                            output logic [3:0] fl, output uhbp_rd_type ev);
        drive(sel, idx, hi ? 4'b1110 : 4'b0010);
        @(posedge clock);
        {read_strobe_n, read_strobe_hi, write_strobe_n, write_strobe_hi} <= 4'b1010;
        #1;
        d = data_in;
        fl[3:2] = {data_oe, drive_disable_n};
        ev = rd_evt;
        @(posedge clock);
        #1;
        fl[1:0] = {data_oe, drive_disable_n};
    endtask : bus_read

    // Latch pulse for a multiplexed host: high one cycle, then fall with the address
    task automatic latch_addr(input logic [2:0] sel, input logic [IDX_W-1:0] idx);
        @(posedge clock);
        addr_latch_n <= 1'b1;
        @(posedge clock);
        addr_latch_n <= 1'b0;
        {select_a_hi, select_b_hi, select_c_n} <= sel;
        reg_index <= idx;
    endtask : latch_addr
endmodule : uhbp_host_model
`default_nettype wire

// *** testbench/uhbp_port_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module uhbp_port_bench
    import uhbp_pkg::*;
;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    logic              clock, rstn, ce;
    logic [IDX_W-1:0]  reg_index;
    logic              select_a_hi, select_b_hi, select_c_n, addr_latch_n;
    logic              read_strobe_n, read_strobe_hi, write_strobe_n, write_strobe_hi;
    logic [DATA_W-1:0] data_in, data_out, exp_mem [REG_COUNT];
    logic              data_oe, drive_disable_n, selected_indicator;
    uhbp_wr_type       wr_evt;
    uhbp_rd_type       rd_evt;
    int                n_fail, n_compared, cycles;

    uhbp_port uhbp_port_inst (.clock, .rstn, .ce, .reg_index, .select_a_hi, .select_b_hi,
        .select_c_n, .addr_latch_n, .read_strobe_n, .read_strobe_hi, .write_strobe_n,
        .write_strobe_hi, .data_in, .data_out, .data_oe, .drive_disable_n,
        .selected_indicator, .wr_evt, .rd_evt);
    uhbp_host_model uhbp_host_model_inst (.clock, .reg_index, .select_a_hi, .select_b_hi,
        .select_c_n, .addr_latch_n, .read_strobe_n, .read_strobe_hi, .write_strobe_n,
        .write_strobe_hi, .data_in, .data_out, .data_oe, .drive_disable_n,
        .selected_indicator, .wr_evt, .rd_evt);

    // 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // Whole run needs under a hundred cycles; a hang is cut well after
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK(data_oe, 1'b0)
        `CHK(drive_disable_n, 1'b1)
        `CHK(selected_indicator, 1'b0)
        `CHK({wr_evt.valid, rd_evt.valid}, 2'b00)
        $display("test reset done");
    endtask : t_reset

    // Every index, both write strobes in turn
    task automatic t_write_all();
        uhbp_wr_type ev;
        logic        ind;
        for (int k = 0; k < REG_COUNT; k++) begin
            uhbp_host_model_inst.bus_write(3'b110, k[2:0], exp_mem[k], k[0], ev, ind);
            `CHK(ev, {1'b1, k[2:0], exp_mem[k]})
            `CHK(ind, 1'b1)
        end
        $display("test write_all done");
    endtask : t_write_all

    // Read back through the bus itself, both read strobes in turn
    task automatic t_read_all();
        logic [DATA_W-1:0] d;
        logic [3:0]        fl;
        uhbp_rd_type       rv;
        for (int k = 0; k < REG_COUNT; k++) begin
            uhbp_host_model_inst.bus_read(3'b110, k[2:0], ~k[0], d, fl, rv);
            `CHK(d, exp_mem[k])
            `CHK(fl, 4'b1001)
            `CHK(rv, {1'b1, k[2:0]})
        end
        $display("test read_all done");
    endtask : t_read_all

    // Each select off in turn: strobes must leave no trace
    task automatic t_unselected();
        logic [2:0]        off [3] = '{3'b010, 3'b100, 3'b111};
        uhbp_wr_type       ev;
        logic              ind;
        logic [DATA_W-1:0] d;
        logic [3:0]        fl;
        uhbp_rd_type       rv;
        for (int j = 0; j < 3; j++) begin
            uhbp_host_model_inst.bus_write(off[j], 3'd2, ~exp_mem[2], j[0], ev, ind);
            `CHK({ev.valid, ind}, 2'b00)
            uhbp_host_model_inst.bus_read(off[j], 3'd2, j[0], d, fl, rv);
            `CHK({fl, rv.valid}, 5'b01010)
        end
        uhbp_host_model_inst.bus_read(3'b110, 3'd2, 1'b0, d, fl, rv);
        `CHK(d, exp_mem[2])
        $display("test unselected done");
    endtask : t_unselected

    // Enable low: a full selected write leaves no trace, outputs hold
    task automatic t_freeze();
        uhbp_wr_type       ev;
        logic              ind;
        logic [DATA_W-1:0] d;
        logic [3:0]        fl;
        uhbp_rd_type       rv;
        @(posedge clock);
        ce <= 1'b0;
        uhbp_host_model_inst.bus_write(3'b110, 3'd3, ~exp_mem[3], 1'b0, ev, ind);
        `CHK({ev.valid, ind}, 2'b01)
        @(posedge clock);
        ce <= 1'b1;
        uhbp_host_model_inst.bus_read(3'b110, 3'd3, 1'b1, d, fl, rv);
        `CHK(d, exp_mem[3])
        $display("test freeze done");
    endtask : t_freeze

    // Captured address wins over pins that have moved on
    task automatic t_latch();
        logic [DATA_W-1:0] d;
        logic [3:0]        fl;
        uhbp_rd_type       rv;
        uhbp_host_model_inst.latch_addr(3'b110, 3'd5);
        uhbp_host_model_inst.bus_read(3'b000, 3'd1, 1'b0, d, fl, rv);
        `CHK(d, exp_mem[5])
        `CHK(rv, {1'b1, 3'd5})
        $display("test latch done");
    endtask : t_latch

    // Main sequence; latch test last since it leaves tied-low mode
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        n_fail = 0;
        n_compared = 0;
        cycles = 0;
        for (int k = 0; k < REG_COUNT; k++) exp_mem[k] = 8'h3C ^ 8'(k * 37);
        repeat (7) @(posedge clock);
        #1;
        t_reset();
        @(posedge clock);
        rstn <= 1'b1;
        t_write_all();
        t_read_all();
        t_unselected();
        t_freeze();
        t_latch();
        give_verdict();
    end
endmodule : uhbp_port_bench
`default_nettype wire
